// ---- hw/fuc_top.sv ----
// Flash update command frame checker and responder
`timescale 1ns/1ps
`include "fuc_cfg.svh"
module fuc_top
    import fuc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Command byte stream in
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    // Response byte stream out
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready,
    // Flash programming side
    output logic prog_start,
    output logic [7:0] prog_cmd,
    output logic [7:0] prog_sub,
    output logic prog_valid,
    output logic [7:0] prog_data,
    output logic prog_commit,
    output logic prog_abort,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Interrupt
    output logic irq
);
    fuc_regs_t q;
    fuc_regs_t n;
    logic rst_n;
    logic acc;
    logic [7:0] c16_data;
    logic [15:0] c16_out;
    logic [31:0] c32_out;
    logic [2:0] ev;
    logic [5:0] nidx;

    fuc_rst_sync u_rst (
        .mclk(mclk),
        .arst_n(arst_n),
        .rst_n(rst_n)
    );

    fuc_crc #(.W(16), .POLY(`FUC_CRC16_POLY)) u_crc16 (
        .crc_in(q.crc16),
        .data(c16_data),
        .crc_out(c16_out)
    );

    fuc_crc #(.W(32), .POLY(`FUC_CRC32_POLY)) u_crc32 (
        .crc_in(q.crc32),
        .data(rx_data),
        .crc_out(c32_out)
    );

    // Header bytes of the response, checksum bytes excepted
    function automatic logic [7:0] resp_byte(
        input logic [5:0] i,
        input logic [7:0] cmd,
        input logic [7:0] sub,
        input logic [7:0] res
    );
        case (i)
            `FUC_OFS_PRE_HI: resp_byte = 8'(`FUC_PREAMBLE >> 8);
            `FUC_OFS_PRE_LO: resp_byte = 8'(`FUC_PREAMBLE);
            `FUC_OFS_REV: resp_byte = `FUC_REVISION;
            `FUC_OFS_CMD: resp_byte = cmd;
            `FUC_OFS_SUB: resp_byte = sub;
            `FUC_OFS_STS: resp_byte = res;
            // Flags, length, data checksum and the rest stay zero
            default: resp_byte = 8'h00;
        endcase
    endfunction : resp_byte

    function automatic logic cmd_known(input logic [7:0] c);
        case (c)
            `FUC_CMD_BOOT, `FUC_CMD_APP, `FUC_CMD_LENS: cmd_known = 1'b1;
            `FUC_CMD_TOF, `FUC_CMD_COLOR, `FUC_CMD_EXTR: cmd_known = 1'b1;
            default: cmd_known = 1'b0;
        endcase
    endfunction : cmd_known

    assign acc = rx_valid && q.rx_ready;
    assign c16_data = (q.st == FUC_S_RSP) ? q.tx_data : rx_data;

    always_comb
    begin
        n = q;
        ev = 3'h0;
        nidx = q.idx + 6'h01;
        n.prog_start = 1'b0;
        n.prog_valid = 1'b0;
        n.prog_commit = 1'b0;
        n.prog_abort = 1'b0;

        case (q.st)
            FUC_S_HDR:
            begin
                if (acc)
                begin
                    n.idx = nidx;
                    // Checksum runs over bytes 02 to 3D only
                    if (q.idx >= `FUC_OFS_REV && q.idx <= `FUC_OFS_DCRC_LAST)
                    begin
                        n.crc16 = c16_out;
                    end
                    case (q.idx)
                        `FUC_OFS_PRE_HI, `FUC_OFS_PRE_LO:
                            n.pre = {q.pre[7:0], rx_data};
                        `FUC_OFS_REV: n.rev = rx_data;
                        `FUC_OFS_CMD: n.cmd = rx_data;
                        `FUC_OFS_SUB: n.sub = rx_data;
                        `FUC_OFS_HCRC_HI, `FUC_OFS_HCRC_LO:
                            n.hcrc = {q.hcrc[7:0], rx_data};
                        default:
                        begin
                            if (q.idx >= `FUC_OFS_LEN_FIRST
                                && q.idx <= `FUC_OFS_LEN_LAST)
                            begin
                                n.len = {q.len[23:0], rx_data};
                            end
                            if (q.idx >= `FUC_OFS_DCRC_FIRST
                                && q.idx <= `FUC_OFS_DCRC_LAST)
                            begin
                                n.dcrc = {q.dcrc[23:0], rx_data};
                            end
                        end
                    endcase
                    if (q.idx == `FUC_OFS_HCRC_LO)
                    begin
                        n.st = FUC_S_EVAL;
                    end
                end
            end
            FUC_S_EVAL:
            begin
                if (q.pre != `FUC_PREAMBLE || q.rev != `FUC_REVISION)
                begin
                    n.res = `FUC_RES_BAD_HDR;
                end
                else if (q.hcrc != q.crc16)
                begin
                    n.res = `FUC_RES_BAD_HCRC;
                end
                else if (!cmd_known(q.cmd))
                begin
                    n.res = `FUC_RES_BAD_CMD;
                end
                else
                begin
                    n.res = `FUC_RES_OK;
                end
                if (n.res != `FUC_RES_OK)
                begin
                    // Header rejected: nothing is programmed
                    ev[`FUC_EV_ERR] = 1'b1;
                    n.st = FUC_S_RSP;
                    n.idx = 6'h00;
                    n.crc16 = `FUC_CRC16_INIT;
                    n.tx_valid = 1'b1;
                    n.tx_data = resp_byte(6'h00, q.cmd, q.sub, n.res);
                    n.tx_last = 1'b0;
                end
                else
                begin
                    n.prog_start = 1'b1;
                    n.prog_cmd = q.cmd;
                    if (q.cmd == `FUC_CMD_BOOT || q.cmd == `FUC_CMD_APP)
                    begin
                        n.prog_sub = 8'h00;
                    end
                    else
                    begin
                        n.prog_sub = q.sub;
                    end
                    n.cnt = q.len;
                    n.crc32 = `FUC_CRC32_INIT;
                    // Payload starts right after the 64-byte header
                    n.st = (q.len == 32'h0) ? FUC_S_DONE : FUC_S_PAY;
                end
            end
            FUC_S_PAY:
            begin
                if (acc)
                begin
                    n.prog_valid = 1'b1;
                    n.prog_data = rx_data;
                    n.crc32 = c32_out;
                    n.cnt = q.cnt - 32'h1;
                    if (q.cnt == 32'h1)
                    begin
                        n.st = FUC_S_DONE;
                    end
                end
            end
            FUC_S_DONE:
            begin
                // Checksum is always checked whatever flag bit 0 says
                if (q.crc32 == q.dcrc)
                begin
                    n.res = `FUC_RES_OK;
                    n.prog_commit = 1'b1;
                    ev[`FUC_EV_OK] = 1'b1;
                end
                else
                begin
                    n.res = `FUC_RES_BAD_DCRC;
                    n.prog_abort = 1'b1;
                    ev[`FUC_EV_ERR] = 1'b1;
                end
                n.st = FUC_S_RSP;
                n.idx = 6'h00;
                n.crc16 = `FUC_CRC16_INIT;
                n.tx_valid = 1'b1;
                n.tx_data = resp_byte(6'h00, q.cmd, q.sub, n.res);
                n.tx_last = 1'b0;
            end
            FUC_S_RSP:
            begin
                if (q.tx_valid && tx_ready)
                begin
                    if (q.tx_last)
                    begin
                        n.tx_valid = 1'b0;
                        n.tx_last = 1'b0;
                        n.st = FUC_S_HDR;
                        n.idx = 6'h00;
                        n.crc16 = `FUC_CRC16_INIT;
                        ev[`FUC_EV_RSP] = 1'b1;
                    end
                    else
                    begin
                        n.idx = nidx;
                        if (q.idx >= `FUC_OFS_REV
                            && q.idx <= `FUC_OFS_DCRC_LAST)
                        begin
                            n.crc16 = c16_out;
                        end
                        if (nidx == `FUC_OFS_HCRC_HI)
                        begin
                            n.tx_data = c16_out[15:8];
                        end
                        else if (nidx == `FUC_OFS_HCRC_LO)
                        begin
                            n.tx_data = q.crc16[7:0];
                        end
                        else
                        begin
                            n.tx_data = resp_byte(nidx, q.cmd, q.sub, q.res);
                        end
                        n.tx_last = (nidx == `FUC_OFS_HCRC_LO);
                    end
                end
            end
            default:
            begin
                n.st = FUC_S_HDR;
                n.idx = 6'h00;
            end
        endcase

        // Register writes
        if (reg_wr && reg_addr == `FUC_REG_CTRL)
        begin
            n.ctrl_en = reg_wdata[0];
        end
        if (reg_wr && reg_addr == `FUC_REG_MASK)
        begin
            n.mask = reg_wdata[2:0];
        end

        // Register reads, data valid in the following cycle
        n.rdata = 32'h0;
        if (reg_rd)
        begin
            case (reg_addr)
                `FUC_REG_CTRL: n.rdata = {31'h0, q.ctrl_en};
                `FUC_REG_STAT: n.rdata = {29'h0, q.status};
                `FUC_REG_MASK: n.rdata = {29'h0, q.mask};
                `FUC_REG_RES: n.rdata = {8'h0, q.cmd, q.sub, q.res};
                `FUC_REG_LEN: n.rdata = q.len;
                default: n.rdata = 32'h0;
            endcase
        end

        // Sticky events: a new event wins over the read clear
        if (reg_rd && reg_addr == `FUC_REG_STAT)
        begin
            n.status = ev;
        end
        else
        begin
            n.status = q.status | ev;
        end
        n.irq = |(n.status & n.mask);

        n.rx_ready = n.ctrl_en && (n.st == FUC_S_HDR || n.st == FUC_S_PAY);
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
            q.st <= FUC_S_HDR;
            q.crc16 <= `FUC_CRC16_INIT;
            q.crc32 <= `FUC_CRC32_INIT;
            q.ctrl_en <= `FUC_CTRL_RST;
            q.mask <= `FUC_MASK_RST;
        end
        else
        begin
            q <= n;
        end
    end

    assign rx_ready = q.rx_ready;
    assign tx_valid = q.tx_valid;
    assign tx_data = q.tx_data;
    assign tx_last = q.tx_last;
    assign prog_start = q.prog_start;
    assign prog_cmd = q.prog_cmd;
    assign prog_sub = q.prog_sub;
    assign prog_valid = q.prog_valid;
    assign prog_data = q.prog_data;
    assign prog_commit = q.prog_commit;
    assign prog_abort = q.prog_abort;
    assign reg_rdata = q.rdata;
    assign irq = q.irq;
endmodule : fuc_top

// ---- hw/fuc_cfg.svh ----
// Constants of the flash update command frame checker
`ifndef FUC_CFG_SVH
`define FUC_CFG_SVH

// Frame markers
`define FUC_PREAMBLE 16'hA1EC
`define FUC_REVISION 8'h03

// Command codes
`define FUC_CMD_BOOT 8'h0B
`define FUC_CMD_APP 8'h0C
`define FUC_CMD_LENS 8'h15
`define FUC_CMD_TOF 8'h29
`define FUC_CMD_COLOR 8'h2A
`define FUC_CMD_EXTR 8'h2B

// Header byte offsets
`define FUC_OFS_PRE_HI 6'h00
`define FUC_OFS_PRE_LO 6'h01
`define FUC_OFS_REV 6'h02
`define FUC_OFS_CMD 6'h03
`define FUC_OFS_SUB 6'h04
`define FUC_OFS_STS 6'h05
`define FUC_OFS_LEN_FIRST 6'h08
`define FUC_OFS_LEN_LAST 6'h0B
`define FUC_OFS_DCRC_FIRST 6'h3A
`define FUC_OFS_DCRC_LAST 6'h3D
`define FUC_OFS_HCRC_HI 6'h3E
`define FUC_OFS_HCRC_LO 6'h3F
`define FUC_OFS_PAYLOAD 7'h40

// Checksums
`define FUC_CRC16_POLY 16'h1021
`define FUC_CRC16_INIT 16'h0000
`define FUC_CRC32_POLY 32'h04C11DB7
`define FUC_CRC32_INIT 32'h0FFFFFFF

// Result codes
`define FUC_RES_OK 8'h00
`define FUC_RES_BAD_HDR 8'h01
`define FUC_RES_BAD_HCRC 8'h02
`define FUC_RES_BAD_CMD 8'h03
`define FUC_RES_BAD_DCRC 8'h04

// Register offsets and reset values
`define FUC_REG_CTRL 8'h00
`define FUC_REG_STAT 8'h04
`define FUC_REG_MASK 8'h08
`define FUC_REG_RES 8'h0C
`define FUC_REG_LEN 8'h10
`define FUC_CTRL_RST 1'b1
`define FUC_MASK_RST 3'h0

// Event bit positions
`define FUC_EV_OK 0
`define FUC_EV_ERR 1
`define FUC_EV_RSP 2

`endif

// ---- hw/fuc_pkg.sv ----
// Types of the flash update command frame checker
package fuc_pkg;

    typedef enum logic [2:0] {
        FUC_S_HDR = 3'b000,
        FUC_S_EVAL = 3'b001,
        FUC_S_PAY = 3'b010,
        FUC_S_DONE = 3'b011,
        FUC_S_RSP = 3'b100
    } fuc_state_t;

    typedef struct packed {
        fuc_state_t st;
        logic [5:0] idx;
        logic [31:0] cnt;
        logic [15:0] pre;
        logic [7:0] rev;
        logic [7:0] cmd;
        logic [7:0] sub;
        logic [31:0] len;
        logic [31:0] dcrc;
        logic [15:0] hcrc;
        logic [15:0] crc16;
        logic [31:0] crc32;
        logic [7:0] res;
        logic ctrl_en;
        logic [2:0] status;
        logic [2:0] mask;
        logic [31:0] rdata;
        logic irq;
        logic rx_ready;
        logic tx_valid;
        logic [7:0] tx_data;
        logic tx_last;
        logic prog_start;
        logic [7:0] prog_cmd;
        logic [7:0] prog_sub;
        logic prog_valid;
        logic [7:0] prog_data;
        logic prog_commit;
        logic prog_abort;
    } fuc_regs_t;

endpackage : fuc_pkg

// ---- hw/fuc_crc.sv ----
// One byte step of an MSB-first CRC with a chosen polynomial
`timescale 1ns/1ps
module fuc_crc #(
    parameter int W = 16,
    parameter logic [W-1:0] POLY = '0
) (
    // Checksum in and out
    input wire logic [W-1:0] crc_in,
    input wire logic [7:0] data,
    output logic [W-1:0] crc_out
);
    logic [W-1:0] c;
    logic fb;

    always_comb
    begin
        c = crc_in;
        fb = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            fb = c[W-1] ^ data[i];
            c = {c[W-2:0], 1'b0} ^ (fb ? POLY : '0);
        end
        crc_out = c;
    end
endmodule : fuc_crc

// ---- hw/fuc_rst_sync.sv ----
// Reset release synchroniser
`timescale 1ns/1ps
module fuc_rst_sync (
    // Clock and raw reset
    input wire logic mclk,
    input wire logic arst_n,
    // Released reset
    output logic rst_n
);
    logic meta_r;
    logic sync_r;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end
        else
        begin
            meta_r <= 1'b1;
            sync_r <= meta_r;
        end
    end

    assign rst_n = sync_r;
endmodule : fuc_rst_sync

// ---- verif/fuc_top_sva.sv ----
// Concurrent checks on the ports of the frame checker
`timescale 1ns/1ps
`include "fuc_cfg.svh"
module fuc_top_sva (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Streams
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_ready,
    // Flash side
    input wire logic prog_start,
    input wire logic [7:0] prog_cmd,
    input wire logic [7:0] prog_sub,
    input wire logic prog_valid,
    input wire logic prog_commit,
    input wire logic prog_abort,
    // Register port and interrupt
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // Position of the response byte on offer
    logic [5:0] idx_r;
    always_ff @(posedge mclk or negedge arst_n)
        if (!arst_n)
            idx_r <= 6'h00;
        else if (tx_valid && tx_ready)
            idx_r <= idx_r + 6'h01;
    pre_bytes_a: assert property (tx_valid && idx_r < 6'h02 |->
        tx_data == (idx_r == 6'h00 ? 8'hA1 : 8'hEC))
        else $error("response marker byte wrong");
    rev_byte_a: assert property (tx_valid && idx_r == 6'h02 |->
        tx_data == `FUC_REVISION) else $error("response revision wrong");
    zero_fields_a: assert property (tx_valid &&
        idx_r inside {[8:11], [58:61]} |-> tx_data == 8'h00)
        else $error("response length or data checksum not zero");
    last_byte_a: assert property (tx_valid |->
        tx_last == (idx_r == 6'h3F)) else $error("tx_last misplaced");
    tx_hold_a: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_data)) else $error("response byte dropped");
    boot_sub_a: assert property (prog_start && (prog_cmd ==
        `FUC_CMD_BOOT || prog_cmd == `FUC_CMD_APP) |-> prog_sub == 8'h00)
        else $error("subcommand not ignored");
    known_cmd_a: assert property (prog_start |-> prog_cmd inside
        {`FUC_CMD_BOOT, `FUC_CMD_APP, `FUC_CMD_LENS, `FUC_CMD_TOF,
        `FUC_CMD_COLOR, `FUC_CMD_EXTR}) else $error("unknown command run");
    end_rsp_a: assert property (prog_commit || prog_abort |->
        tx_valid && !prog_valid && !(prog_commit && prog_abort))
        else $error("verdict without response");
    rsp_quiet_a: assert property (tx_valid |-> !rx_ready &&
        !prog_valid) else $error("input taken during response");
    start_once_a: assert property (prog_start |=> !prog_start [*8])
        else $error("start pulse repeated");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    cover property (prog_commit);
    cover property (prog_abort);
    cover property (irq);
    cover property (tx_valid && !tx_ready);
endmodule : fuc_top_sva

bind fuc_top fuc_top_sva fuc_top_sva_i (.mclk(mclk), .arst_n(arst_n),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .prog_start(prog_start),
    .prog_cmd(prog_cmd), .prog_sub(prog_sub), .prog_valid(prog_valid),
    .prog_commit(prog_commit), .prog_abort(prog_abort), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));

// ---- verif/fuc_host_model.sv ----
// Host that sends command frames and takes response bytes
`timescale 1ns/1ps
module fuc_host_model (
    // Clock
    input wire logic mclk,
    // Command stream
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic rx_ready,
    // Response stream
    output logic tx_ready
);
    logic [7:0] mem [0:127];
    logic slow;
    initial
    begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b1;
        slow = 1'b0;
    end
    // A slow host stalls the response at random
    always @(posedge mclk)
        tx_ready <= slow ? 1'($urandom_range(1, 0)) : 1'b1;
    // Header first, file bytes after it, as filled
    task automatic send(input int n);
        for (int i = 0; i < n; i++)
        begin
            rx_valid <= 1'b1;
            rx_data <= mem[i];
            @(posedge mclk);
            while (!rx_ready)
                @(posedge mclk);
        end
        rx_valid <= 1'b0;
        rx_data <= ~mem[n - 1];
    endtask : send
endmodule : fuc_host_model

// ---- verif/flash_update_command_frame_tb_top.sv ----
// Self-checking bench of the flash update command frame checker
`timescale 1ns/1ps
`include "fuc_cfg.svh"
module flash_update_command_frame_tb_top;
    logic mclk, arst_n, reg_wr, reg_rd, rx_valid, rx_ready, tx_valid;
    logic tx_last, tx_ready, irq, prog_start, prog_valid, prog_commit;
    logic prog_abort, rd_d;
    logic [7:0] rx_data, tx_data, reg_addr, prog_cmd, prog_sub, prog_data;
    logic [31:0] reg_wdata, reg_rdata;
    logic [7:0] exp_tx[$], exp_pd[$], fr [0:127];
    logic [15:0] exp_ps[$];
    logic exp_end[$];
    logic [31:0] exp_rd[$];
    int errors, checked;
    logic [7:0] cmds [0:5] = '{`FUC_CMD_BOOT, `FUC_CMD_APP, `FUC_CMD_LENS,
        `FUC_CMD_TOF, `FUC_CMD_COLOR, `FUC_CMD_EXTR};

    fuc_top fuc_top_i (.mclk(mclk), .arst_n(arst_n), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
        .prog_start(prog_start), .prog_cmd(prog_cmd), .prog_sub(prog_sub),
        .prog_valid(prog_valid), .prog_data(prog_data),
        .prog_commit(prog_commit), .prog_abort(prog_abort),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    fuc_host_model fuc_host_model_i (.mclk(mclk), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_ready(rx_ready), .tx_ready(tx_ready));

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task chk(input string name, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, e, g);
        end
    endtask : chk

    function automatic logic [15:0] c16(logic [15:0] c, logic [7:0] d);
        c = c ^ {d, 8'h00};
        for (int k = 0; k < 8; k++)
            c = c[15] ? (c << 1) ^ `FUC_CRC16_POLY : c << 1;
        return c;
    endfunction : c16

    function automatic logic [31:0] c32(logic [31:0] c, logic [7:0] d);
        c = c ^ {d, 24'h000000};
        for (int k = 0; k < 8; k++)
            c = c[31] ? (c << 1) ^ `FUC_CRC32_POLY : c << 1;
        return c;
    endfunction : c32

    // Header checksum over bytes 02..3D, high byte first
    task seal(input logic flip);
        logic [15:0] h;
        h = 16'h0000;
        for (int i = 2; i < 62; i++)
            h = c16(h, fr[i]);
        {fr[62], fr[63]} = flip ? ~h : h;
    endtask : seal

    task wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        // One edge apart, so reg_rd is never set twice in one step
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
    endtask : rd

    // Bad: 1 marker, 2 header checksum, 3 data checksum
    task automatic frame(input logic [7:0] cmd, sub, input int len, bad);
        logic [31:0] d;
        logic [7:0] res;
        int n;
        res = bad == 1 ? `FUC_RES_BAD_HDR : bad == 2 ? `FUC_RES_BAD_HCRC :
            !(cmd inside {cmds}) ? `FUC_RES_BAD_CMD :
            bad == 3 ? `FUC_RES_BAD_DCRC : `FUC_RES_OK;
        d = `FUC_CRC32_INIT;
        for (int i = 0; i < 128; i++)
            fr[i] = (i < 64 || i >= 64 + len) ? 8'h00 : 8'($urandom);
        for (int i = 64; i < 64 + len; i++)
            d = c32(d, fr[i]);
        {fr[0], fr[1]} = bad == 1 ? 16'hA1ED : `FUC_PREAMBLE;
        fr[2] = `FUC_REVISION;
        fr[3] = cmd;
        fr[4] = sub;
        {fr[8], fr[9], fr[10], fr[11]} = len;
        {fr[58], fr[59], fr[60], fr[61]} = bad == 3 ? ~d : d;
        seal(bad == 2);
        n = 64;
        if (res == `FUC_RES_OK || res == `FUC_RES_BAD_DCRC)
        begin
            n = 64 + len;
            exp_ps.push_back({cmd, cmd == `FUC_CMD_BOOT ||
                cmd == `FUC_CMD_APP ? 8'h00 : sub});
            for (int i = 64; i < n; i++)
                exp_pd.push_back(fr[i]);
            exp_end.push_back(res == `FUC_RES_OK);
        end
        for (int i = 0; i < n; i++)
            fuc_host_model_i.mem[i] = fr[i];
        for (int i = 6; i < 64; i++)
            fr[i] = 8'h00;
        fr[0] = 8'hA1;
        fr[1] = 8'hEC;
        fr[5] = res;
        seal(1'b0);
        for (int i = 0; i < 64; i++)
            exp_tx.push_back(fr[i]);
        fuc_host_model_i.send(n);
        for (int t = 0; t < 3000 && exp_tx.size() != 0; t++)
            @(posedge mclk);
        chk("rsp_done", 0, exp_tx.size());
    endtask : frame

    always @(posedge mclk)
    begin
        if (tx_valid && tx_ready)
        begin
            chk("tx_last", exp_tx.size() == 1, tx_last);
            chk("tx_data", exp_tx.pop_front(), tx_data);
        end
        if (prog_start)
            chk("prog_cs", exp_ps.pop_front(), {prog_cmd, prog_sub});
        if (prog_valid)
            chk("prog_data", exp_pd.pop_front(), prog_data);
        if (prog_commit || prog_abort)
            chk("prog_ok", exp_end.pop_front(), prog_commit);
        if (rd_d)
            chk("reg_rdata", exp_rd.pop_front(), reg_rdata);
        rd_d <= reg_rd;
    end

    task results;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    initial
    begin
        repeat (20000) @(posedge mclk);
        errors++;
        results();
    end

    initial
    begin
        arst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        errors = 0;
        checked = 0;
        void'($urandom(50261));
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        rd(`FUC_REG_CTRL, 32'h1);
        rd(`FUC_REG_MASK, 32'h0);
        rd(8'h14, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            fuc_host_model_i.slow = i[0];
            frame(cmds[i], 8'($urandom), i, 0);
        end
        repeat (2) @(posedge mclk);
        chk("irq", 0, irq);
        wr(`FUC_REG_MASK, 32'h4);
        repeat (3) @(posedge mclk);
        chk("irq", 1, irq);
        rd(`FUC_REG_STAT, 32'h5);
        repeat (3) @(posedge mclk);
        chk("irq", 0, irq);
        frame(`FUC_CMD_APP, 8'h00, 4, 1);
        frame(`FUC_CMD_TOF, 8'h02, 5, 2);
        frame(8'h07, 8'h00, 0, 0);
        frame(`FUC_CMD_LENS, 8'h03, 7, 3);
        rd(`FUC_REG_STAT, 32'h6);
        rd(`FUC_REG_RES, {8'h00, `FUC_CMD_LENS, 8'h03, `FUC_RES_BAD_DCRC});
        rd(`FUC_REG_LEN, 32'h7);
        wr(`FUC_REG_CTRL, 32'h0);
        repeat (3) @(posedge mclk);
        chk("rx_ready", 0, rx_ready);
        wr(`FUC_REG_CTRL, 32'h1);
        repeat (3) @(posedge mclk);
        chk("rx_ready", 1, rx_ready);
        chk("left", 0, exp_pd.size() + exp_ps.size() + exp_end.size());
        results();
    end
endmodule : flash_update_command_frame_tb_top
